// >>> verilog/irq_ranker.sv
// Shared constants and the combinational ranking of pending sources.
// Assumes pending requests are already gated by their enables.
`default_nettype none

// ==========================================================================
// Constants
package irq_pkg;
   localparam int NUM_SRC = 16;
   localparam int IDX_W   = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CORE_EN  = 8'h00;
   localparam logic [7:0] OFS_CORE_PRI = 8'h04;
   localparam logic [7:0] OFS_EXT_EN   = 8'h08;
   localparam logic [7:0] OFS_EXT_PRI  = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_MASK     = 8'h14;
   localparam logic [7:0] OFS_SERVICE  = 8'h18;

   // Source index in natural order
   localparam int SRC_PF     = 0;
   localparam int SRC_SERIAL = 5;
   localparam int SRC_AM     = 7;
   localparam int SRC_TW1    = 8;
   localparam int SRC_CONV   = 9;
   localparam int SRC_TW2    = 10;
   localparam int SRC_KB     = 11;
   localparam int SRC_PB1    = 12;
   localparam int SRC_KD     = 13;
   localparam int SRC_WD     = 14;
   localparam int SRC_PB2    = 15;
   localparam int CORE_SRCS  = 7;
   localparam int EXT_SRCS   = 8;

   // Field positions
   localparam int GLOBAL_EN_BIT = 7;
   localparam int SER_RX_BIT    = 0;
   localparam int SER_TX_BIT    = 1;
   localparam int WDC_WATCHDOG_PERIODIC_FLAG_BIT  = 3;
   localparam int WDC_PF_BIT    = 4;
   localparam int WDC_PFEN_BIT  = 5;
   localparam int TW_FLAG_BIT   = 4;
   localparam int CONV_EOC_BIT  = 6;
   localparam int BUF_FULL_BIT  = 1;
   localparam int ST_TAKEN      = 0;
   localparam int ST_PREEMPT    = 1;
   localparam int ST_BADRET     = 2;
   localparam int ST_W          = 3;

   // Vectors and levels
   localparam logic [7:0] VEC_BASE   = 8'h03;
   localparam logic [7:0] VEC_STEP   = 8'h08;
   localparam logic [7:0] VEC_PF     = 8'h33;
   localparam logic [7:0] VEC_SERIAL = 8'h23;
   localparam logic [3:0] VEC_GAP    = 4'h6;
   localparam logic [1:0] LVL_LOW    = 2'h0;
   localparam logic [1:0] LVL_HIGH   = 2'h1;
   localparam logic [1:0] LVL_PF     = 2'h2;

   // Vector slot 33h is taken by power fail, so later slots skip it
   function automatic logic [7:0] vector_of(input logic [IDX_W-1:0] idx);
      logic [7:0] slot;
      slot = {4'h0, idx};
      if (idx == IDX_W'(SRC_PF)) begin
         return VEC_PF;
      end
      if (idx <= VEC_GAP) begin
         slot = slot - 8'h01;
      end
      return 8'(VEC_BASE + 8'(VEC_STEP * slot));
   endfunction

   // Level now in service plus one; zero when idle
   function automatic logic [1:0] ceiling_of(input logic [2:0] is);
      if (is[2]) begin
         return 2'h3;
      end
      if (is[1]) begin
         return 2'h2;
      end
      return {1'b0, is[0]};
   endfunction
endpackage

// ==========================================================================
// Ranker
module irq_ranker #(
   parameter int NUM_SRC = 16,
   parameter int IDX_W   = 4
) (
   // Requests
   input  wire logic [NUM_SRC-1:0] pending_in,
   input  wire logic [NUM_SRC-1:0] high_in,
   // Winner
   output logic                    found_out,
   output logic [IDX_W-1:0]        index_out,
   output logic [1:0]              level_out
);
   always_comb begin
      logic [1:0] lv;
      lv        = irq_pkg::LVL_LOW;
      found_out = 1'b0;
      index_out = '0;
      level_out = irq_pkg::LVL_LOW;
      // Scan upward-to-downward so the lowest index wins a tie
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (i == irq_pkg::SRC_PF) begin
            lv = irq_pkg::LVL_PF;
         end else begin
            lv = high_in[i] ? irq_pkg::LVL_HIGH : irq_pkg::LVL_LOW;
         end
         if (pending_in[i] && (!found_out || lv >= level_out)) begin
            found_out = 1'b1;
            index_out = IDX_W'(i);
            level_out = lv;
         end
      end
   end
endmodule // irq_ranker

`default_nettype wire

// >>> verilog/prioritized_interrupt_controller.sv
// Sixteen-source prioritized interrupt controller with APB registers.
// Assumes flag inputs come from logic on sys_clk_in and that the core
// pulses ack only while irq_req_out is high.
`default_nettype none

// ==========================================================================
// Overview of operation
// - Sixteen sources arbitrated across three priority levels.
// - Enabled power-fail request outranks every other source.
// - Every other source is software set to high or low level.
// - Equal-level ties resolve by fixed natural order, power fail first.
// - Fixed vectors eight bytes apart, 03h to 7Bh; power fail 33h.
// - Serial port requests at 23h on transmit-done or receive-done.
// - Eight newer sources use extended enable/priority bits 0 to 7.
// - Each two-wire port requests from bit 4 of its control register.
// - Converter requests from end-of-conversion bit 6, extended bit 1.
// - Keyboard and power buffers request from buffer-full bit 1.
// - Watchdog periodic requests from control bit 3, extended bit 6.
// - Key detect requests on any of eight flags, extended bit 5.
module prioritized_interrupt_controller (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Source flags
   input  wire logic        ext_irq_zero_in,
   input  wire logic        timer_zero_overflow_in,
   input  wire logic        ext_irq_one_in,
   input  wire logic        timer_one_overflow_in,
   input  wire logic        timer_two_overflow_in,
   input  wire logic [7:0]  serial_control_reg_in,
   input  wire logic [7:0]  activity_monitor_flags_in,
   input  wire logic [7:0]  twowire_port1_ctrl_in,
   input  wire logic [7:0]  twowire_port2_ctrl_in,
   input  wire logic [7:0]  converter_control1_reg_in,
   input  wire logic [7:0]  keyboard_status_in,
   input  wire logic [7:0]  power_buffer1_status_in,
   input  wire logic [7:0]  power_buffer2_status_in,
   input  wire logic [7:0]  key_detect_flags_in,
   input  wire logic [7:0]  watchdog_control_reg_in,
   // Processor core
   input  wire logic        ack_in,
   input  wire logic        reti_in,
   output logic             irq_req_out,
   output logic [7:0]       vector_out,
   output logic [1:0]       level_out,
   // Controller events
   output logic             ctl_irq_out
);
   localparam int N = irq_pkg::NUM_SRC;
   localparam int W = irq_pkg::IDX_W;

   typedef struct packed {
      logic [7:0]              core_en;
      logic [6:0]              core_pri;
      logic [7:0]              ext_en;
      logic [7:0]              ext_pri;
      logic [irq_pkg::ST_W-1:0] status;
      logic [irq_pkg::ST_W-1:0] mask;
      logic [2:0]              in_service;
      logic                    req;
      logic [7:0]              vector;
      logic [1:0]              level;
      logic [W-1:0]            index;
      logic [31:0]             rdata;
      logic                    slverr;
   } state_t;

   state_t q;
   state_t next_q;

   logic [N-1:0] raw;
   logic [N-1:0] en_vec;
   logic [N-1:0] hi_vec;
   logic [N-1:0] pending;
   logic         win_found;
   logic [W-1:0] win_idx;
   logic [1:0]   win_lvl;

   // =======================================================================
   // Source gathering
   always_comb begin
      raw = '0;
      raw[irq_pkg::SRC_PF] =
         watchdog_control_reg_in[irq_pkg::WDC_PF_BIT];
      raw[1] = ext_irq_zero_in;
      raw[2] = timer_zero_overflow_in;
      raw[3] = ext_irq_one_in;
      raw[4] = timer_one_overflow_in;
      raw[irq_pkg::SRC_SERIAL] =
         serial_control_reg_in[irq_pkg::SER_TX_BIT] |
         serial_control_reg_in[irq_pkg::SER_RX_BIT];
      raw[6] = timer_two_overflow_in;
      raw[irq_pkg::SRC_AM]   = |activity_monitor_flags_in;
      raw[irq_pkg::SRC_TW1]  =
         twowire_port1_ctrl_in[irq_pkg::TW_FLAG_BIT];
      raw[irq_pkg::SRC_TW2]  =
         twowire_port2_ctrl_in[irq_pkg::TW_FLAG_BIT];
      raw[irq_pkg::SRC_CONV] =
         converter_control1_reg_in[irq_pkg::CONV_EOC_BIT];
      raw[irq_pkg::SRC_KB]   =
         keyboard_status_in[irq_pkg::BUF_FULL_BIT];
      raw[irq_pkg::SRC_PB1]  =
         power_buffer1_status_in[irq_pkg::BUF_FULL_BIT];
      raw[irq_pkg::SRC_PB2]  =
         power_buffer2_status_in[irq_pkg::BUF_FULL_BIT];
      raw[irq_pkg::SRC_KD]   = |key_detect_flags_in;
      raw[irq_pkg::SRC_WD]   =
         watchdog_control_reg_in[irq_pkg::WDC_WATCHDOG_PERIODIC_FLAG_BIT];
   end

   // Global enable gates only core sources 1 to 7; power fail has its own enable
   assign en_vec = {q.ext_en,
                    q.core_en[irq_pkg::CORE_SRCS-1:0]
                       & {irq_pkg::CORE_SRCS{q.core_en[7]}},
                    watchdog_control_reg_in[irq_pkg::WDC_PFEN_BIT]};
   assign hi_vec  = {q.ext_pri, q.core_pri, 1'b1};
   assign pending = raw & en_vec;

   irq_ranker #(
      .NUM_SRC (N),
      .IDX_W   (W)
   ) u_ranker (
      .pending_in (pending),
      .high_in    (hi_vec),
      .found_out  (win_found),
      .index_out  (win_idx),
      .level_out  (win_lvl)
   );

   // =======================================================================
   // Next state
   logic setup;
   logic wr;
   logic take;

   assign setup = psel_in & ~penable_in;
   assign wr    = psel_in & penable_in & pwrite_in;
   assign take  = ack_in & q.req;

   always_comb begin
      logic [irq_pkg::ST_W-1:0] set;
      logic [irq_pkg::ST_W-1:0] clr;
      set    = '0;
      clr    = '0;
      next_q = q;

      // Return retires the highest level in service
      if (reti_in) begin
         if (q.in_service == 3'h0) begin
            set[irq_pkg::ST_BADRET] = 1'b1;
         end else if (q.in_service[2]) begin
            next_q.in_service[2] = 1'b0;
         end else if (q.in_service[1]) begin
            next_q.in_service[1] = 1'b0;
         end else begin
            next_q.in_service[0] = 1'b0;
         end
      end
      if (take) begin
         next_q.in_service[q.level] = 1'b1;
         set[irq_pkg::ST_TAKEN] = 1'b1;
         set[irq_pkg::ST_PREEMPT] = (q.in_service != 3'h0);
      end

      // Built from the updated service state to avoid a double take
      next_q.req = win_found &&
         ((3'({1'b0, win_lvl}) + 3'h1) >
          {1'b0, irq_pkg::ceiling_of(next_q.in_service)});
      next_q.vector = irq_pkg::vector_of(win_idx);
      next_q.level  = win_lvl;
      next_q.index  = win_idx;

      if (wr) begin
         case (paddr_in)
            irq_pkg::OFS_CORE_EN:  next_q.core_en  = pwdata_in[7:0];
            irq_pkg::OFS_CORE_PRI: next_q.core_pri = pwdata_in[6:0];
            irq_pkg::OFS_EXT_EN:   next_q.ext_en   = pwdata_in[7:0];
            irq_pkg::OFS_EXT_PRI:  next_q.ext_pri  = pwdata_in[7:0];
            irq_pkg::OFS_STATUS:   clr = pwdata_in[irq_pkg::ST_W-1:0];
            irq_pkg::OFS_MASK:
               next_q.mask = pwdata_in[irq_pkg::ST_W-1:0];
            default: ;
         endcase
      end
      // A new event beats a clear in the same cycle
      next_q.status = (q.status & ~clr) | set;

      // Read data is prepared in setup and shown in the access cycle
      if (setup) begin
         next_q.slverr = 1'b0;
         case (paddr_in)
            irq_pkg::OFS_CORE_EN:  next_q.rdata = {24'h0, q.core_en};
            irq_pkg::OFS_CORE_PRI: next_q.rdata = {25'h0, q.core_pri};
            irq_pkg::OFS_EXT_EN:   next_q.rdata = {24'h0, q.ext_en};
            irq_pkg::OFS_EXT_PRI:  next_q.rdata = {24'h0, q.ext_pri};
            irq_pkg::OFS_STATUS:   next_q.rdata = {29'h0, q.status};
            irq_pkg::OFS_MASK:     next_q.rdata = {29'h0, q.mask};
            irq_pkg::OFS_SERVICE:
               next_q.rdata = {13'h0, q.in_service, q.vector,
                               5'h0, q.req, q.level};
            default: begin
               next_q.rdata  = 32'h0000_0000;
               next_q.slverr = 1'b1;
            end
         endcase
      end
   end

   // =======================================================================
   // State register
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign prdata_out  = q.rdata;
   assign pready_out  = 1'b1;
   assign pslverr_out = q.slverr & psel_in & penable_in;
   assign irq_req_out = q.req;
   assign vector_out  = q.vector;
   assign level_out   = q.level;
   assign ctl_irq_out = |(q.status & q.mask);

   // =======================================================================
   // Assertions
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   localparam logic [1:0] LVL_LOW_C = irq_pkg::LVL_LOW;

   logic tie_lower;
   always_comb begin
      tie_lower = 1'b0;
      for (int i = 1; i < N; i++) begin
         if (i < int'(win_idx) && pending[i] &&
             {1'b0, hi_vec[i]} == win_lvl) begin
            tie_lower = 1'b1;
         end
      end
   end

   sixteen_found_a: assert property (win_found == (|pending))
      else $error("winner flag disagrees with pending sources");
   pf_top_a: assert property (
      pending[irq_pkg::SRC_PF] |->
         win_idx == W'(irq_pkg::SRC_PF) && win_lvl == irq_pkg::LVL_PF)
      else $error("power fail did not win");
   user_level_a: assert property (
      win_found && win_idx != W'(irq_pkg::SRC_PF) |->
         win_lvl == {1'b0, hi_vec[win_idx]})
      else $error("winner level does not match its priority bit");
   natural_order_a: assert property (win_found |-> !tie_lower)
      else $error("lower index at same level was passed over");
   vector_map_a: assert property (
      irq_req_out |->
         vector_out == irq_pkg::vector_of($past(win_idx)))
      else $error("vector does not match ranked source");
   serial_vec_a: assert property (
      pending == N'(1 << irq_pkg::SRC_SERIAL) &&
         next_q.in_service == 3'h0 |=>
         irq_req_out && vector_out == irq_pkg::VEC_SERIAL)
      else $error("serial request not presented at its vector");
   ext_gate_a: assert property (
      !q.ext_en[irq_pkg::SRC_PB2 - irq_pkg::SRC_TW1] |->
         !pending[irq_pkg::SRC_PB2])
      else $error("extended enable bit 7 did not gate");
   twowire_flag_a: assert property (
      pending[irq_pkg::SRC_TW2] |->
         twowire_port2_ctrl_in[irq_pkg::TW_FLAG_BIT] && q.ext_en[2])
      else $error("two-wire request without its flag");
   conv_flag_a: assert property (
      pending[irq_pkg::SRC_CONV] |=> irq_req_out || $past(!win_found)
         || $past(next_q.in_service != 3'h0) || $past(win_idx) <
         W'(irq_pkg::SRC_CONV) || $past(win_lvl) != LVL_LOW_C)
      else $error("converter request not presented");
   buffer_flag_a: assert property (
      pending[irq_pkg::SRC_KB] |->
         keyboard_status_in[irq_pkg::BUF_FULL_BIT] && q.ext_en[3])
      else $error("keyboard request without buffer full");
   watchdog_flag_a: assert property (
      pending[irq_pkg::SRC_WD] |->
         watchdog_control_reg_in[irq_pkg::WDC_WATCHDOG_PERIODIC_FLAG_BIT] && q.ext_en[6])
      else $error("watchdog request without its flag");
   key_detect_a: assert property (
      (|key_detect_flags_in) && q.ext_en[5] && q.core_en[7] |->
         pending[irq_pkg::SRC_KD])
      else $error("key detect flags did not raise a request");
   preempt_only_a: assert property (
      take |=> q.in_service[$past(q.level)] &&
         (!irq_req_out ||
          3'({1'b0, q.level}) + 3'h1 >
          {1'b0, irq_pkg::ceiling_of(q.in_service)}))
      else $error("request at or below level in service");

   take_c: cover property (take);
   preempt_c: cover property (take && q.in_service != 3'h0);
   pf_win_c: cover property (irq_req_out && vector_out == irq_pkg::VEC_PF);
   reti_c: cover property (reti_in && q.in_service != 3'h0);
endmodule // prioritized_interrupt_controller

`default_nettype wire

// >>> sim/core_model.sv
// Processor core stand-in: takes presented interrupts and returns.
// Assumes the controller's registered request on the same clock.
`default_nettype none

// ==========================================================================
// Core model
module core_model (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       reset_in,
   // Controller side
   input  wire logic       irq_req_in,
   output logic            ack_out,
   output logic            reti_out,
   // Bench control
   input  wire logic       ack_en_in,
   input  wire logic [3:0] ack_wait_in,
   input  wire logic       ret_in,
   output logic [7:0]      takes_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_cnt;
   // Ack only a request seen high; never twice for one request
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ack_out <= 1'b0;
         reti_out <= 1'b0;
         wait_cnt <= 4'h0;
         takes_out <= 8'h00;
      end else begin
         reti_out <= ret_in;
         ack_out <= 1'b0;
         wait_cnt <= (irq_req_in && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
         if (irq_req_in && ack_en_in && !ack_out
             && wait_cnt >= ack_wait_in) begin
            ack_out <= 1'b1;
            takes_out <= takes_out + 8'h01;
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule // core_model
`default_nettype wire

// >>> sim/prioritized_interrupt_controller_bench.sv
// Self-checking bench for the prioritized interrupt controller.
// Assumes the core model and the design share one 40 MHz clock.
`default_nettype none

// ==========================================================================
// Bench
module prioritized_interrupt_controller_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [15:0] f;
      logic [7:0]  cp;
      logic [7:0]  ep;
      logic [7:0]  vec;
      logic [1:0]  lvl;
   } row_t;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, ctl, ack, reti, ret = 1'b0, ack_en = 1'b0;
   logic e0 = 1'b0, t0 = 1'b0, e1 = 1'b0, t1 = 1'b0, t2 = 1'b0;
   logic [7:0] scon = 8'h00, am = 8'h00, tw1 = 8'h00, tw2 = 8'h00;
   logic [7:0] conv = 8'h00, kb = 8'h00, pb1 = 8'h00, pb2 = 8'h00;
   logic [7:0] kd = 8'h00, wdc = 8'h00, vec, takes;
   logic [1:0] lvl;
   logic [3:0] ack_wait = 4'h2;
   logic slverr_seen = 1'b0;
   int fail_count = 0, compares = 0;
   // Rows: flags, core and extended priority, expected vector and level
   row_t rows [9] = '{
      '{16'hFFFE, 8'h00, 8'h00, 8'h03, 2'h0},
      '{16'hFFFE, 8'h00, 8'h80, 8'h7B, 2'h1},
      '{16'hFFFF, 8'h7F, 8'hFF, 8'h33, 2'h2},
      '{16'h8006, 8'h02, 8'h00, 8'h0B, 2'h1},
      '{16'h6000, 8'h00, 8'h40, 8'h73, 2'h1},
      '{16'h6000, 8'h00, 8'h00, 8'h6B, 2'h0},
      '{16'h0300, 8'h00, 8'h02, 8'h4B, 2'h1},
      '{16'h00A0, 8'h00, 8'h00, 8'h23, 2'h0},
      '{16'hFFFE, 8'h7F, 8'hFF, 8'h03, 2'h1}};

   always #12.5 clk = ~clk;

   prioritized_interrupt_controller prioritized_interrupt_controller_i (
      .sys_clk_in(clk), .reset_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .ext_irq_zero_in(e0),
      .timer_zero_overflow_in(t0), .ext_irq_one_in(e1),
      .timer_one_overflow_in(t1), .timer_two_overflow_in(t2),
      .serial_control_reg_in(scon), .activity_monitor_flags_in(am),
      .twowire_port1_ctrl_in(tw1), .twowire_port2_ctrl_in(tw2),
      .converter_control1_reg_in(conv), .keyboard_status_in(kb),
      .power_buffer1_status_in(pb1), .power_buffer2_status_in(pb2),
      .key_detect_flags_in(kd), .watchdog_control_reg_in(wdc),
      .ack_in(ack), .reti_in(reti), .irq_req_out(irq),
      .vector_out(vec), .level_out(lvl), .ctl_irq_out(ctl));

   core_model core_model_i (
      .sys_clk_in(clk), .reset_in(rst), .irq_req_in(irq),
      .ack_out(ack), .reti_out(reti), .ack_en_in(ack_en),
      .ack_wait_in(ack_wait), .ret_in(ret), .takes_out(takes));

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      slverr_seen = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      chk(32'(n < 20), 32'h1);
      if (n >= 20) print_verdict();
   endtask

   // Unused flag bits are driven high so stray bits cannot pass unseen
   task automatic set_src(input logic [15:0] s, input logic alt);
      @(posedge clk);
      wdc <= {2'h3, s[0], s[0], s[14], 3'h7};
      {t1, e1, t0, e0} <= s[4:1];
      scon <= {6'h3F, s[5] & alt, s[5] & !alt};
      t2 <= s[6];
      am <= s[7] ? (alt ? 8'h01 : 8'h80) : 8'h00;
      tw1 <= {3'h7, s[8], 4'hF};
      conv <= {1'b1, s[9], 6'h3F};
      tw2 <= {3'h7, s[10], 4'hF};
      kb <= {6'h3F, s[11], 1'b1};
      pb1 <= {6'h3F, s[12], 1'b1};
      kd <= s[13] ? (alt ? 8'h01 : 8'h80) : 8'h00;
      pb2 <= {6'h3F, s[15], 1'b1};
   endtask

   task automatic wait_req(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) begin
         fail_count++;
         $display("ERROR %0t: request wait timed out", $time);
         print_verdict();
      end
   endtask

   task automatic core_return();
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   function automatic logic [7:0] exp_vec(input int i);
      if (i == 0) return 8'h33;
      if (i <= 6) return 8'(8'h03 + 8 * (i - 1));
      return 8'(8'h03 + 8 * i);
   endfunction

   initial begin
      #2500000;
      fail_count++;
      $display("ERROR %0t: run timed out", $time);
      print_verdict();
   end

   initial begin
      logic [31:0] rd;
      int i;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({irq, ctl, pready}, 32'h1);
      apb(1'b0, irq_pkg::OFS_CORE_EN, 32'h0, rd);
      chk(rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0, rd);
      chk({rd[30:0], slverr_seen}, 32'h1);
      apb(1'b1, irq_pkg::OFS_CORE_EN, 32'hFF, rd);
      apb(1'b1, irq_pkg::OFS_EXT_EN, 32'hFF, rd);
      apb(1'b0, irq_pkg::OFS_CORE_EN, 32'h0, rd);
      chk(rd, 32'hFF);
      $display("test registers done");
      for (i = 0; i < 32; i++) begin
         set_src(16'h1 << (i % 16), 1'(i / 16));
         wait_req(1'b1);
         chk(32'(vec), 32'(exp_vec(i % 16)));
         chk(32'(lvl), (i % 16 == 0) ? 32'h2 : 32'h0);
         set_src(16'h0, 1'b0);
         wait_req(1'b0);
      end
      $display("test vectors done");
      foreach (rows[k]) begin
         apb(1'b1, irq_pkg::OFS_CORE_PRI, 32'(rows[k].cp), rd);
         apb(1'b1, irq_pkg::OFS_EXT_PRI, 32'(rows[k].ep), rd);
         set_src(rows[k].f, 1'b0);
         wait_req(1'b1);
         chk({vec, 6'h0, lvl}, {rows[k].vec, 6'h0, rows[k].lvl});
         set_src(16'h0, 1'b0);
         wait_req(1'b0);
      end
      $display("test ranking done");
      apb(1'b1, irq_pkg::OFS_CORE_PRI, 32'h0, rd);
      apb(1'b1, irq_pkg::OFS_EXT_PRI, 32'h80, rd);
      ack_en <= 1'b1;
      set_src(16'h0002, 1'b0);
      wait_req(1'b1);
      wait_req(1'b0);
      set_src(16'h0006, 1'b0);
      repeat (5) @(posedge clk);
      chk({irq, takes}, 32'h1);
      set_src(16'h8006, 1'b0);
      wait_req(1'b1);
      chk({vec, 6'h0, lvl}, 16'h7B01);
      wait_req(1'b0);
      ack_en <= 1'b0;
      apb(1'b0, irq_pkg::OFS_STATUS, 32'h0, rd);
      chk(rd, 32'h3);
      apb(1'b0, irq_pkg::OFS_SERVICE, 32'h0, rd);
      chk(32'(rd[18:16]), 32'h3);
      chk(32'(ctl), 32'h0);
      apb(1'b1, irq_pkg::OFS_MASK, 32'h3, rd);
      @(posedge clk);
      chk(32'(ctl), 32'h1);
      apb(1'b1, irq_pkg::OFS_STATUS, 32'h1, rd);
      @(posedge clk);
      chk(32'(ctl), 32'h1);
      apb(1'b1, irq_pkg::OFS_STATUS, 32'h2, rd);
      @(posedge clk);
      chk(32'(ctl), 32'h0);
      $display("test preemption done");
      set_src(16'h0006, 1'b0);
      core_return();
      chk(32'(irq), 32'h0);
      core_return();
      wait_req(1'b1);
      chk(32'(vec), 32'h03);
      set_src(16'h0, 1'b0);
      core_return();
      apb(1'b0, irq_pkg::OFS_STATUS, 32'h0, rd);
      chk(rd, 32'h4);
      chk(32'(ctl), 32'h0);
      apb(1'b1, irq_pkg::OFS_MASK, 32'h4, rd);
      @(posedge clk);
      chk(32'(ctl), 32'h1);
      @(posedge clk);
      wdc <= 8'h10;
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h0);
      $display("test return done");
      // Mid-run reset must clear status, ctl and the core enables
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, irq_pkg::OFS_STATUS, 32'h0, rd);
      chk(rd, 32'h0);
      chk(32'(ctl), 32'h0);
      apb(1'b0, irq_pkg::OFS_CORE_EN, 32'h0, rd);
      chk(rd, 32'h0);
      $display("test reset done");
      print_verdict();
   end
endmodule // prioritized_interrupt_controller_bench
`default_nettype wire
